/* rtl/mac_params.svh */
// Constants for the multiply-accumulate status and mode control block
// Included by the package users; holds definitions only

`ifndef MAC_PARAMS_SVH
`define MAC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map, byte addresses on APB
// ----------------------------------------------------------------------
`define MAC_AW 8
`define MAC_STATUS_OFS 8'h00
`define MAC_ACC_OFS 8'h04
`define MAC_IRQ_STAT_OFS 8'h08
`define MAC_IRQ_MASK_OFS 8'h0C

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define MAC_STATUS_W 8
`define MAC_STATUS_RST 8'h00
`define BIT_SAT 7
`define BIT_UNS 6
`define BIT_FRAC 5
`define BIT_ROUND 4
`define BIT_NEG 3
`define BIT_ZERO 2
`define BIT_OVF 1
`define BIT_CARRY 0
`define MAC_RSVD_W 24

// ----------------------------------------------------------------------
// Accumulator constants
// ----------------------------------------------------------------------
`define MAC_ACC_RST 32'h0000_0000
`define MAC_SAT_POS 32'h7FFF_FFFF
`define MAC_SAT_NEG 32'h8000_0000
`define MAC_SAT_UMAX 32'hFFFF_FFFF
`define MAC_SAT_UMIN 32'h0000_0000
`define MAC_HALF32 32'h8000_0000
`define MAC_CLIP16 16'h7FFF

// ----------------------------------------------------------------------
// Interrupt status and mask
// ----------------------------------------------------------------------
`define IRQ_OVF 0
`define IRQ_SAT 1
`define IRQ_W 2
`define IRQ_RST 2'h0

`endif

/* rtl/mac_pkg.sv */
// Types shared by the multiply-accumulate control and datapath
// Assumes nothing beyond a SystemVerilog compiler

package mac_pkg;

  // Operations issued by the execution pipeline
  typedef enum logic [2:0]
  {
    OP_IDLE,
    OP_MULTIPLY_ACC,
    OP_MULTIPLY_SUBTRACT,
    OP_LOAD_ACC,
    OP_SIGNED_MULTIPLY,
    OP_UNSIGNED_MULTIPLY,
    OP_STORE_ACC
  } macOp_e;

endpackage : mac_pkg

/* rtl/mac_op_if.sv */
// Bundle between the control block and the arithmetic datapath
// Assumes the datapath is purely combinational

`timescale 1ns/1ps

interface mac_op_if;
  import mac_pkg::*;

  // Mode bits and operation from the control side
  logic saturate;
  logic unsignedMode;
  logic fractional;
  logic roundMode;
  logic hold;
  logic opLong;
  macOp_e op;
  logic [31:0] opA;
  logic [31:0] opB;
  logic [31:0] acc;
  // Results from the datapath
  logic [31:0] accNext;
  logic [31:0] satValue;
  logic [31:0] mulResult;
  logic [31:0] storeValue;
  logic overflow;

  modport ctrl
  (
    output saturate, unsignedMode, fractional, roundMode, hold, opLong,
    output op, opA, opB, acc,
    input accNext, satValue, mulResult, storeValue, overflow
  );

  modport arith
  (
    input saturate, unsignedMode, fractional, roundMode, hold, opLong,
    input op, opA, opB, acc,
    output accNext, satValue, mulResult, storeValue, overflow
  );
endinterface : mac_op_if

/* rtl/mac_arith.sv */
// Combinational multiply, accumulate, saturate and store rounding
// Assumes the control side holds the operands stable for the cycle

`timescale 1ns/1ps
`include "mac_params.svh"

module mac_arith
(
  // Operation in, results out
  mac_op_if.arith opIf
);
  import mac_pkg::*;

  // Sign or zero extend a word or long operand to 33 bits
  function automatic logic [32:0] extend(input logic [31:0] v,
                                         input logic wide,
                                         input logic sgn);
    extend = wide ? {sgn & v[31], v} : {{17{sgn & v[15]}}, v[15:0]};
  endfunction : extend

  // ----------------------------------------------------------------------
  // Multiplier
  // ----------------------------------------------------------------------
  wire isSub = (opIf.op == OP_MULTIPLY_SUBTRACT);
  wire isAccOp = (opIf.op == OP_MULTIPLY_ACC) | isSub;
  // Fractions are always signed; integers follow the unsigned bit
  wire accSigned = opIf.fractional | ~opIf.unsignedMode;
  wire mulSigned = (opIf.op == OP_SIGNED_MULTIPLY) | (isAccOp & accSigned);
  wire [32:0] extA = extend(opIf.opA, opIf.opLong, mulSigned);
  wire [32:0] extB = extend(opIf.opB, opIf.opLong, mulSigned);
  wire signed [65:0] prodFull = $signed(extA) * $signed(extB);

  // ----------------------------------------------------------------------
  // Fractional alignment and product rounding
  // ----------------------------------------------------------------------
  // A fraction product carries two sign bits, so shift left by one
  wire [63:0] fracLong = {prodFull[62:0], 1'b0};
  wire [31:0] fracHi = fracLong[63:32];
  wire [31:0] fracLo = fracLong[31:0];
  // Halfway rounds toward the even upper half; cleared bit truncates
  wire roundUp = opIf.roundMode & ((fracLo > `MAC_HALF32) |
                 ((fracLo == `MAC_HALF32) & fracHi[0]));
  wire [31:0] fracVal = opIf.opLong ? fracHi + {31'h0, roundUp}
                                    : {prodFull[30:0], 1'b0};
  wire [31:0] value = opIf.fractional ? fracVal : prodFull[31:0];

  // ----------------------------------------------------------------------
  // Accumulate and saturate
  // ----------------------------------------------------------------------
  wire [32:0] extV = {accSigned & value[31], value};
  wire [32:0] extAcc = {accSigned & opIf.acc[31], opIf.acc};
  wire [32:0] sum = isSub ? extAcc - extV : extAcc + extV;
  // Signed overflow shows as a sign mismatch, unsigned as carry or borrow
  wire ovfRaw = accSigned ? (sum[32] ^ sum[31]) : sum[32];
  wire posDir = isSub ? value[31] : ~value[31];
  assign opIf.satValue = accSigned ?
    (posDir ? `MAC_SAT_POS : `MAC_SAT_NEG) :
    (isSub ? `MAC_SAT_UMIN : `MAC_SAT_UMAX);
  assign opIf.overflow = isAccOp & ~opIf.hold & ovfRaw;
  // A held accumulator ignores accumulate operations
  assign opIf.accNext = opIf.hold ? opIf.acc :
    (opIf.overflow & opIf.saturate) ? opIf.satValue : sum[31:0];
  assign opIf.mulResult = prodFull[31:0];

  // ----------------------------------------------------------------------
  // Accumulator store, optionally rounded to 16 bits
  // ----------------------------------------------------------------------
  wire up16 = opIf.acc[15] & ((opIf.acc[14:0] != 15'h0) | opIf.acc[16]);
  wire [16:0] rnd17 = {opIf.acc[31], opIf.acc[31:16]} + {16'h0, up16};
  // Rounding the top positive value would wrap, so it clips instead
  wire [15:0] r16 = (rnd17[16] ^ rnd17[15]) ? `MAC_CLIP16 : rnd17[15:0];
  assign opIf.storeValue = (opIf.fractional & opIf.unsignedMode) ?
    {16'h0, r16} : opIf.acc;

endmodule : mac_arith

/* rtl/mac_status_mode_control.sv */
// Status and mode control of the multiply-accumulate unit
// Assumes an APB master and a pipeline issuing at most one op a cycle,
// both on clock
//
// Summary of operation
// - Overflow with saturation loads saturation constant
// - Saturated accumulator ignores accumulates until cleared
// - Signed saturation to most positive or negative
// - Unsigned saturation to zero or all ones
// - Unsigned bit picks integer signedness and constants
// - Fractional store with bit clear is full
// - Fractional store rounds to sixteen bits, even
// - Fraction bit selects fraction or integer operands
// - Fractions are signed two's complement values
// - Truncate drops product low bits
// - Round mode rounds long product, ties even
// - Negative flag follows result sign bit
// - Zero flag set when result zero
// - Only accumulate and load ops update flags
// - Overflow sticky until accumulator or status load
//
// Our own choices: the APB slave port and the register offsets.

`timescale 1ns/1ps
`include "mac_params.svh"

module mac_status_mode_control
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // APB slave
  input wire logic [`MAC_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pipeline operation
  input wire logic opValid,
  input wire mac_pkg::macOp_e opCode,
  input wire logic opLong,
  input wire logic [31:0] opA,
  input wire logic [31:0] opB,
  input wire logic [31:0] opLoad,
  // Results and interrupt
  output logic resultValid,
  output logic [31:0] resultData,
  output logic irq
);
  import mac_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [`MAC_STATUS_W-1:0] status_q;
  logic [`MAC_STATUS_W-1:0] status_d;
  logic [31:0] acc_q;
  logic [31:0] acc_d;
  logic [`IRQ_W-1:0] irqStat_q;
  logic [`IRQ_W-1:0] irqStat_d;
  logic [`IRQ_W-1:0] irqMask_q;
  logic [`IRQ_W-1:0] irqMask_d;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic resultValid_q;
  logic [31:0] resultData_q;
  logic irq_q;

  mac_op_if opIf ();

  mac_arith arith
  (
    .opIf (opIf.arith)
  );

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  // Zero wait state: ready rises in the access phase after each setup
  wire setup = psel & ~penable;
  wire access = psel & penable & pready_q;
  wire hitStatus = (paddr == `MAC_STATUS_OFS);
  wire hitAcc = (paddr == `MAC_ACC_OFS);
  wire hitIrqStat = (paddr == `MAC_IRQ_STAT_OFS);
  wire hitIrqMask = (paddr == `MAC_IRQ_MASK_OFS);
  wire mapped = hitStatus | hitAcc | hitIrqStat | hitIrqMask;
  wire wrEn = access & pwrite;
  wire wrStatus = wrEn & hitStatus;
  wire wrAcc = wrEn & hitAcc;
  wire wrIrqStat = wrEn & hitIrqStat;
  wire wrIrqMask = wrEn & hitIrqMask;

  // Read data, reserved status bits forced low
  wire [31:0] statusWord = {{`MAC_RSVD_W{1'b0}}, status_q};
  wire [31:0] rdWord =
    hitStatus ? statusWord :
    hitAcc ? acc_q :
    hitIrqStat ? {{(32-`IRQ_W){1'b0}}, irqStat_q} :
    hitIrqMask ? {{(32-`IRQ_W){1'b0}}, irqMask_q} : 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Operation decode
  // ----------------------------------------------------------------------
  wire accumOp = opValid & ((opCode == OP_MULTIPLY_ACC) |
                            (opCode == OP_MULTIPLY_SUBTRACT));
  wire loadOp = opValid & (opCode == OP_LOAD_ACC);
  wire mulOp = opValid & ((opCode == OP_SIGNED_MULTIPLY) |
                          (opCode == OP_UNSIGNED_MULTIPLY));
  wire storeOp = opValid & (opCode == OP_STORE_ACC);
  // A pipeline load or accumulate op wins over an APB accumulator write in the same cycle
  wire accLoad = loadOp | (wrAcc & ~accumOp);
  wire [31:0] loadValue = loadOp ? opLoad : pwdata;
  wire ovfEvent = accumOp & opIf.overflow;
  wire satEvent = ovfEvent & status_q[`BIT_SAT];

  // Datapath inputs
  assign opIf.saturate = status_q[`BIT_SAT];
  assign opIf.unsignedMode = status_q[`BIT_UNS];
  assign opIf.fractional = status_q[`BIT_FRAC];
  assign opIf.roundMode = status_q[`BIT_ROUND];
  // Saturation latched: held until overflow cleared or a direct load
  assign opIf.hold = status_q[`BIT_SAT] & status_q[`BIT_OVF];
  assign opIf.opLong = opLong;
  assign opIf.op = opCode;
  assign opIf.opA = opA;
  assign opIf.opB = opB;
  assign opIf.acc = acc_q;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  assign acc_d = accLoad ? loadValue : accumOp ? opIf.accNext : acc_q;

  // Status: written modes first, then op flag updates on top so that an
  // overflow in the same cycle as a clearing write is not lost
  always_comb
  begin
    status_d = wrStatus ? pwdata[`MAC_STATUS_W-1:0] : status_q;
    status_d[`BIT_CARRY] = 1'b0;
    if (accLoad)
    begin
      status_d[`BIT_NEG] = loadValue[31];
      status_d[`BIT_ZERO] = (loadValue == 32'h0000_0000);
      status_d[`BIT_OVF] = 1'b0;
    end
    else if (accumOp)
    begin
      status_d[`BIT_NEG] = opIf.accNext[31];
      status_d[`BIT_ZERO] = (opIf.accNext == 32'h0000_0000);
      status_d[`BIT_OVF] = status_d[`BIT_OVF] | opIf.overflow;
    end
  end

  // Interrupt status: write one to clear, a new event wins
  assign irqStat_d = (irqStat_q & ~(wrIrqStat ? pwdata[`IRQ_W-1:0] :
                     `IRQ_RST)) | {satEvent, ovfEvent};
  assign irqMask_d = wrIrqMask ? pwdata[`IRQ_W-1:0] : irqMask_q;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      status_q <= `MAC_STATUS_RST;
      acc_q <= `MAC_ACC_RST;
      irqStat_q <= `IRQ_RST;
      irqMask_q <= `IRQ_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      acc_q <= acc_d;
      irqStat_q <= irqStat_d;
      irqMask_q <= irqMask_d;
      irq_q <= |(irqStat_d & irqMask_d);
    end
  end

  // Bus answer; read data is sampled in the setup cycle
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q <= setup ? rdWord : prdata_q;
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
    end
  end

  // Multiply and store results, one cycle after the op
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      resultValid_q <= 1'b0;
      resultData_q <= 32'h0000_0000;
    end
    else
    begin
      resultValid_q <= mulOp | storeOp;
      resultData_q <= mulOp ? opIf.mulResult : opIf.storeValue;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign resultValid = resultValid_q;
  assign resultData = resultData_q;
  assign irq = irq_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  sequence seqSatOverflow;
    accumOp && opIf.overflow && status_q[`BIT_SAT] && !wrAcc;
  endsequence

  // A bus write to the accumulator in the store cycle would move it
  sequence seqRoundStore;
    storeOp && status_q[`BIT_FRAC] && status_q[`BIT_UNS] && !wrAcc ##1
    resultValid_q;
  endsequence

  chk_sat_const: assert property (
    seqSatOverflow |=> acc_q == $past(opIf.satValue))
    else $error("saturating overflow did not load the constant");

  chk_sat_hold: assert property (
    accumOp && status_q[`BIT_SAT] && status_q[`BIT_OVF] |=> $stable(acc_q))
    else $error("saturated accumulator changed");

  chk_signed_sat: assert property (
    seqSatOverflow and (!status_q[`BIT_UNS] && !status_q[`BIT_FRAC])
    |=> acc_q == `MAC_SAT_POS || acc_q == `MAC_SAT_NEG)
    else $error("signed saturation value wrong");

  chk_unsigned_sat: assert property (
    seqSatOverflow and (status_q[`BIT_UNS] && !status_q[`BIT_FRAC] &&
    opCode == OP_MULTIPLY_ACC) |=> acc_q == `MAC_SAT_UMAX)
    else $error("unsigned add saturation value wrong");

  chk_store_full: assert property (
    storeOp && !(status_q[`BIT_FRAC] && status_q[`BIT_UNS])
    |=> resultValid_q && resultData_q == $past(acc_q))
    else $error("unrounded store differs from accumulator");

  chk_store_round: assert property (
    seqRoundStore |-> resultData_q[31:16] == 16'h0000 && $stable(acc_q))
    else $error("rounded store upper half not zero");

  chk_neg_flag: assert property (
    accumOp || accLoad |=> status_q[`BIT_NEG] == acc_q[31])
    else $error("negative flag does not follow result");

  chk_zero_flag: assert property (
    accumOp || accLoad |=> status_q[`BIT_ZERO] == (acc_q == 32'h0))
    else $error("zero flag does not follow result");

  chk_mul_flags: assert property (
    mulOp && !wrEn |=> $stable(status_q[`BIT_NEG:`BIT_OVF]))
    else $error("plain multiply changed flags");

  chk_ovf_sticky: assert property (
    status_q[`BIT_OVF] && !accLoad && !wrStatus |=> status_q[`BIT_OVF])
    else $error("overflow flag dropped without a load");

  chk_load_clears: assert property (
    accLoad |=> !status_q[`BIT_OVF])
    else $error("direct load left the overflow flag set");

  chk_ready_once: assert property (
    setup |=> pready_q ##1 !pready_q)
    else $error("ready did not pulse for one cycle");

  chk_slverr_unmapped: assert property (
    setup && !mapped |=> pready_q && pslverr_q)
    else $error("unmapped access not flagged as an error");

  chk_rsvd_zero: assert property (
    setup && hitStatus |=> prdata_q[31:`MAC_STATUS_W] == 24'h0 &&
    !prdata_q[`BIT_CARRY])
    else $error("reserved status bits read non-zero");

  // A clearing write set up in the event cycle may end the level early
  chk_irq_level: assert property (
    ovfEvent && irqMask_q[`IRQ_OVF] && !wrIrqMask && !setup |=> irq_q [*2])
    else $error("masked-in overflow did not raise the interrupt");

endmodule : mac_status_mode_control

/* sim/mac_pipe_model.sv */
// Execution pipeline model that issues operations to the unit
// Assumes the unit takes an operation at a rising edge with valid high

`timescale 1ns/1ps

module mac_pipe_model
(
  // Clock
  input wire logic clock,
  // Operation bundle
  output logic opValid,
  output mac_pkg::macOp_e opCode,
  output logic opLong,
  output logic [31:0] opA,
  output logic [31:0] opB,
  output logic [31:0] opLoad
);
  import mac_pkg::*;

  // Idle at time zero
  initial
  begin
    opValid = 1'b0;
    opCode = OP_IDLE;
    opLong = 1'b0;
    opA = 32'h0000_0000;
    opB = 32'h0000_0000;
    opLoad = 32'h0000_0000;
  end

  // One operation for one cycle; operands then turn to their inverse
  // so that a unit sampling late sees a wrong value, not a stale one
  task automatic issue(input macOp_e code, input logic wide,
    input logic [31:0] a, input logic [31:0] b, input logic [31:0] ld);
    @(posedge clock);
    opValid <= 1'b1;
    opCode <= code;
    opLong <= wide;
    opA <= a;
    opB <= b;
    opLoad <= ld;
    @(posedge clock);
    opValid <= 1'b0;
    opCode <= OP_IDLE;
    opA <= ~a;
    opB <= ~b;
    opLoad <= ~ld;
  endtask : issue
endmodule : mac_pipe_model

/* sim/testbench.sv */
// Self-checking bench for the multiply-accumulate status and mode block
// Assumes the design files and the pipeline model compile first

`timescale 1ns/1ps

module testbench;
  import mac_pkg::*;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic opValid;
  macOp_e opCode;
  logic opLong;
  logic [31:0] opA;
  logic [31:0] opB;
  logic [31:0] opLoad;
  logic resultValid;
  logic [31:0] resultData;
  logic irq;
  logic [31:0] rdVal;
  logic errSeen;
  int errors = 0;
  int checks_done = 0;
  logic [7:0] satMode [4] = '{8'h80, 8'h80, 8'hC0, 8'hC0};
  logic [31:0] satLoad [4] = '{32'h7FFF_FFFF, 32'h8000_0000,
    32'hFFFF_FFFF, 32'h0000_0000};
  logic [7:0] satStat [4] = '{8'h82, 8'h8A, 8'hCA, 8'hC6};

  // Half period of the 10 MHz clock
  always #50 clock = ~clock;

  mac_status_mode_control dut
  (
    .clock, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .opValid, .opCode, .opLong, .opA, .opB, .opLoad,
    .resultValid, .resultData, .irq
  );

  mac_pipe_model pipe
  (
    .clock, .opValid, .opCode, .opLong, .opA, .opB, .opLoad
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // APB transfer; no wait bound here, the watchdog cuts a hang short
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    rdVal = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input string what, input logic [7:0] a,
    input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(what, exp, rdVal);
  endtask : rd

  // Operand a doubles as the direct load value
  task automatic op(input macOp_e c, input logic w, input logic [31:0] a,
    input logic [31:0] b);
    pipe.issue(c, w, a, b, a);
  endtask : op

  task automatic both(input string what, input logic [31:0] acc,
    input logic [7:0] st);
    rd(what, 8'h04, acc);
    rd(what, 8'h00, {24'h00_0000, st});
  endtask : both

  // Result pulse is looked at in the cycle that follows the take edge
  task automatic res(input string what, input logic [31:0] exp);
    #1;
    check(what, 32'h1, {31'h0, resultValid});
    check(what, exp, resultData);
  endtask : res

  task automatic mac1(input string what, input logic [7:0] mode,
    input logic w, input logic [31:0] a, input logic [31:0] b,
    input logic [31:0] exp);
    apb(1'b1, 8'h00, {24'h00_0000, mode});
    op(OP_LOAD_ACC, 1'b0, 32'h0000_0000, 32'h0000_0000);
    op(OP_MULTIPLY_ACC, w, a, b);
    rd(what, 8'h04, exp);
  endtask : mac1

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clock);
    errors++;
    complete_run();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    both("reset", 32'h0000_0000, 8'h00);
    rd("unmapped", 8'h10, 32'h0000_0000);
    check("slverr", 32'h1, {31'h0, errSeen});
    apb(1'b1, 8'h00, 32'h0000_00FF);
    rd("reserved", 8'h00, 32'h0000_00FE);
    $display("test registers done");
    apb(1'b1, 8'h00, 32'h0000_0000);
    op(OP_LOAD_ACC, 1'b0, 32'd12, 32'h0000_0000);
    op(OP_MULTIPLY_SUBTRACT, 1'b0, 32'h3, 32'h4);
    both("zero", 32'h0000_0000, 8'h04);
    op(OP_MULTIPLY_ACC, 1'b0, 32'h0000_FFFF, 32'h2);
    both("neg", 32'hFFFF_FFFE, 8'h08);
    op(OP_SIGNED_MULTIPLY, 1'b1, 32'h3, 32'h5);
    res("signed_multiply_op", 32'd15);
    op(OP_UNSIGNED_MULTIPLY, 1'b1, 32'h0000_FFFF, 32'h2);
    res("unsigned_multiply_op", 32'h0001_FFFE);
    both("mul flags", 32'hFFFF_FFFE, 8'h08);
    $display("test flags done");
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, 8'h00, {24'h00_0000, satMode[i]});
      op(OP_LOAD_ACC, 1'b0, satLoad[i], 32'h0000_0000);
      op(i % 2 ? OP_MULTIPLY_SUBTRACT : OP_MULTIPLY_ACC, 1'b0, 1, 1);
      op(i % 2 ? OP_MULTIPLY_ACC : OP_MULTIPLY_SUBTRACT, 1'b0, 1, 1);
      both("saturate", satLoad[i], satStat[i]);
    end
    apb(1'b1, 8'h04, 32'h0000_0005);
    both("acc write", 32'h0000_0005, 8'hC0);
    $display("test saturation done");
    rd("irq stat", 8'h08, 32'h0000_0003);
    check("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, 8'h0C, 32'h0000_0001);
    rd("irq mask", 8'h0C, 32'h0000_0001);
    check("irq on", 32'h1, {31'h0, irq});
    apb(1'b1, 8'h08, 32'h0000_0001);
    rd("irq stat", 8'h08, 32'h0000_0002);
    check("irq off", 32'h0, {31'h0, irq});
    apb(1'b1, 8'h0C, 32'h0000_0002);
    rd("irq mask", 8'h0C, 32'h0000_0002);
    check("irq on", 32'h1, {31'h0, irq});
    apb(1'b1, 8'h08, 32'h0000_0002);
    rd("irq stat", 8'h08, 32'h0000_0000);
    check("irq off", 32'h0, {31'h0, irq});
    // Overflow with saturation off wraps and raises the overflow event
    apb(1'b1, 8'h0C, 32'h0000_0003);
    apb(1'b1, 8'h00, 32'h0000_0000);
    op(OP_LOAD_ACC, 1'b0, 32'h7FFF_FFFF, 32'h0000_0000);
    op(OP_MULTIPLY_ACC, 1'b0, 32'h0000_0001, 32'h0000_0001);
    both("wrap", 32'h8000_0000, 8'h0A);
    rd("irq wrap", 8'h08, 32'h0000_0001);
    check("irq wrap", 32'h1, {31'h0, irq});
    apb(1'b1, 8'h08, 32'h0000_0001);
    rd("irq stat", 8'h08, 32'h0000_0000);
    check("irq off", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    apb(1'b1, 8'h00, 32'h0000_0020);
    op(OP_LOAD_ACC, 1'b0, 32'h1235_8000, 32'h0000_0000);
    op(OP_STORE_ACC, 1'b0, 32'h0000_0000, 32'h0000_0000);
    res("store full", 32'h1235_8000);
    apb(1'b1, 8'h00, 32'h0000_0060);
    op(OP_STORE_ACC, 1'b0, 32'h0000_0000, 32'h0000_0000);
    res("store odd", 32'h0000_1236);
    rd("acc kept", 8'h04, 32'h1235_8000);
    op(OP_LOAD_ACC, 1'b0, 32'h1234_8000, 32'h0000_0000);
    op(OP_STORE_ACC, 1'b0, 32'h0000_0000, 32'h0000_0000);
    res("store even", 32'h0000_1234);
    $display("test store done");
    mac1("frac", 8'h20, 1'b0, 32'h4000, 32'h4000, 32'h2000_0000);
    mac1("int", 8'h00, 1'b0, 32'h4000, 32'h4000, 32'h1000_0000);
    mac1("frac neg", 8'h20, 1'b0, 32'hC000, 32'h4000, 32'hE000_0000);
    mac1("round", 8'h30, 1'b1, 32'h4000_0000, 32'h3, 32'h2);
    mac1("trunc", 8'h20, 1'b1, 32'h4000_0000, 32'h3, 32'h1);
    mac1("unsigned", 8'h40, 1'b0, 32'hFFFF, 32'h2, 32'h0001_FFFE);
    mac1("signed", 8'h00, 1'b0, 32'hFFFF, 32'h2, 32'hFFFF_FFFE);
    $display("test modes done");
    complete_run();
  end
endmodule : testbench
